// [hw/tmr_pkg.sv]
// shared constants and types for the up/down auto-reload timer
package tmr_pkg;

  localparam int unsigned ADDR_W   = 4;
  localparam int unsigned DATA_W   = 8;

  // register offsets
  localparam logic [3:0] OFF_CTRL   = 4'h0;
  localparam logic [3:0] OFF_MODE   = 4'h1;
  localparam logic [3:0] OFF_CNT_LO = 4'h2;
  localparam logic [3:0] OFF_CNT_HI = 4'h3;
  localparam logic [3:0] OFF_RLD_LO = 4'h4;
  localparam logic [3:0] OFF_RLD_HI = 4'h5;
  localparam logic [3:0] OFF_STAT   = 4'h6;
  localparam logic [3:0] OFF_MASK   = 4'h7;

  // field positions
  localparam int unsigned MODE_DOWN_COUNT_ENABLE_BIT = 0;
  localparam int unsigned STAT_OVF_BIT  = 0;
  localparam int unsigned MASK_OVF_BIT  = 0;

  // reset values
  localparam logic [7:0]  CTRL_RST  = 8'h00;
  localparam logic [7:0]  BYTE_RST  = 8'h00;
  localparam logic        BIT_RST   = 1'b0;

  // counting constants
  localparam int unsigned PRESCALE_DIV = 12;
  localparam logic [15:0] CNT_MAX      = 16'hffff;
  localparam logic [15:0] CNT_ZERO     = 16'h0000;

  // pin sync vector positions
  localparam int unsigned PIN_COUNT = 0;
  localparam int unsigned PIN_DIR   = 1;

  typedef struct packed {
    logic ovf_flag;
    logic external_flag;
    logic receive_clock_select;
    logic transmit_clock_select;
    logic rsvd;
    logic run_control_bit;
    logic counter_timer_select;
    logic capture_reload_select;
  } tmr_ctrl_t;

  typedef struct packed {
    logic active;
    logic hit_up;
    logic hit_dn;
    logic wrap;
  } tmr_evt_t;

endpackage

// [hw/tmr_pin_sync.sv]
// two-stage synchroniser with falling edge detect for external pins
`timescale 1ns/1ps
module tmr_pin_sync #(
  parameter int unsigned W = 2
) (
  input  wire logic         clk,    // system clock
  input  wire logic         rst,    // sync reset, active high
  input  wire logic         ce,     // clock enable
  input  wire logic [W-1:0] din,    // raw pin levels
  output logic      [W-1:0] q,      // synchronised levels
  output logic      [W-1:0] fall    // one-cycle falling edge pulses
);

  logic [W-1:0] meta_ff;
  logic [W-1:0] sync_ff;
  logic [W-1:0] prev_ff;

  // first stage feeds only the second stage
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      meta_ff <= '1;
      sync_ff <= '1;
      prev_ff <= '1;
    end
    else if (ce)
    begin
      meta_ff <= din;
      sync_ff <= meta_ff;
      prev_ff <= sync_ff;
    end
  end

  assign q    = sync_ff;
  assign fall = prev_ff & ~sync_ff;

endmodule // tmr_pin_sync

// [hw/tmr_updown_timer.sv]
// 16-bit timer/counter with auto-reload, up/down counting and interrupt
//
// The address map and strobed register access are this design's own decisions.
`timescale 1ns/1ps
module tmr_updown_timer (
  input  wire logic       SYS_CLK,          // 100 MHz system clock
  input  wire logic       RST,              // sync reset, active high
  input  wire logic       CE,               // clock enable, freezes all state
  input  wire logic [3:0] ADDR,             // register address
  input  wire logic [7:0] WDATA,            // write data
  input  wire logic       WR,               // write strobe
  input  wire logic       RD,               // read strobe
  output logic      [7:0] RDATA,            // read data, cycle after RD
  input  wire logic       COUNT_INPUT_PIN,  // external count input
  input  wire logic       DIRECTION_PIN,    // external direction input
  output logic            IRQ               // level interrupt request
);

  ////////////////////////////////////////////////////////////////////////
  // declarations

  tmr_pkg::tmr_ctrl_t ctrl_ff;
  tmr_pkg::tmr_evt_t  evt;
  logic [7:0]         count_low_byte_ff;
  logic [7:0]         count_high_byte_ff;
  logic [7:0]         reload_low_byte_ff;
  logic [7:0]         reload_high_byte_ff;
  logic               down_count_enable_ff;
  logic               mask_ovf_ff;
  logic [3:0]         pre_ff;
  logic [7:0]         rdata_ff;
  logic               irq_ff;
  logic [7:0]         nxt_lo;
  logic [7:0]         nxt_hi;
  logic [7:0]         rd_mux;
  logic [1:0]         pin_q;
  logic [1:0]         pin_fall;
  logic [15:0]        count;
  logic [15:0]        reload;
  logic               tick;
  logic               pre_wrap;
  logic               auto_mode;
  logic               baud_mode;
  logic               updown;
  logic               dir_up;
  logic               reload_en;
  logic               ovf_set;
  logic               ext_tgl;
  logic               cnt_wr;

  function automatic logic sel(input logic [3:0] a, input logic [3:0] off);
    sel = (a == off);
  endfunction

  assign count  = {count_high_byte_ff, count_low_byte_ff};
  assign reload = {reload_high_byte_ff, reload_low_byte_ff};
  assign cnt_wr = WR & (sel(ADDR, tmr_pkg::OFF_CNT_LO) | sel(ADDR, tmr_pkg::OFF_CNT_HI));

  ////////////////////////////////////////////////////////////////////////
  // pin synchronisers

  tmr_pin_sync #(
    .W (2)
  ) u_pin_sync (
    .clk  (SYS_CLK),
    .rst  (RST),
    .ce   (CE),
    .din  ({DIRECTION_PIN, COUNT_INPUT_PIN}),
    .q    (pin_q),
    .fall (pin_fall)
  );

  ////////////////////////////////////////////////////////////////////////
  // input selection and prescaler

  assign pre_wrap = (pre_ff == 4'(tmr_pkg::PRESCALE_DIV - 1));

  always_ff @(posedge SYS_CLK)
  begin
    if (RST)
      pre_ff <= 4'h0;
    else if (CE)
      pre_ff <= pre_wrap ? 4'h0 : pre_ff + 4'h1;
  end

  // counter mode uses the falling edge of the synchronised pin
  assign tick = ctrl_ff.counter_timer_select ? pin_fall[tmr_pkg::PIN_COUNT]
                                             : pre_wrap;

  ////////////////////////////////////////////////////////////////////////
  // mode decode and wrap detection

  assign baud_mode = ctrl_ff.receive_clock_select | ctrl_ff.transmit_clock_select;
  assign auto_mode = ~baud_mode & ~ctrl_ff.capture_reload_select;
  assign reload_en = ~ctrl_ff.capture_reload_select | baud_mode;
  assign updown    = auto_mode & down_count_enable_ff;
  assign dir_up    = ~updown | pin_q[tmr_pkg::PIN_DIR];

  // one process drives every field of the event struct
  always_comb
  begin
    evt.active = CE & ctrl_ff.run_control_bit & tick;
    evt.hit_up = dir_up & (count == tmr_pkg::CNT_MAX);
    evt.hit_dn = ~dir_up & (count == reload);
    evt.wrap   = evt.active & ~cnt_wr & (evt.hit_up | evt.hit_dn);
  end

  assign ovf_set = evt.wrap & ~baud_mode;
  assign ext_tgl = evt.wrap & updown;

  ////////////////////////////////////////////////////////////////////////
  // count registers

  // a software write to either count byte takes that cycle
  always_comb
  begin
    {nxt_hi, nxt_lo} = count;
    if (WR && sel(ADDR, tmr_pkg::OFF_CNT_LO))
      nxt_lo = WDATA;
    else if (WR && sel(ADDR, tmr_pkg::OFF_CNT_HI))
      nxt_hi = WDATA;
    else if (evt.active)
    begin
      if (dir_up)
      begin
        if (evt.hit_up)
          {nxt_hi, nxt_lo} = reload_en ? reload : tmr_pkg::CNT_ZERO;
        else
          {nxt_hi, nxt_lo} = count + 16'h0001;
      end
      else
      begin
        if (evt.hit_dn)
          {nxt_hi, nxt_lo} = tmr_pkg::CNT_MAX;
        else
          {nxt_hi, nxt_lo} = count - 16'h0001;
      end
    end
  end

  always_ff @(posedge SYS_CLK)
  begin
    if (RST)
    begin
      count_low_byte_ff  <= tmr_pkg::BYTE_RST;
      count_high_byte_ff <= tmr_pkg::BYTE_RST;
    end
    else if (CE)
    begin
      count_low_byte_ff  <= nxt_lo;
      count_high_byte_ff <= nxt_hi;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // software registers

  always_ff @(posedge SYS_CLK)
  begin
    if (RST)
    begin
      reload_low_byte_ff   <= tmr_pkg::BYTE_RST;
      reload_high_byte_ff  <= tmr_pkg::BYTE_RST;
      down_count_enable_ff <= tmr_pkg::BIT_RST;
      mask_ovf_ff          <= tmr_pkg::BIT_RST;
    end
    else if (CE && WR)
    begin
      if (sel(ADDR, tmr_pkg::OFF_RLD_LO))
        reload_low_byte_ff <= WDATA;
      if (sel(ADDR, tmr_pkg::OFF_RLD_HI))
        reload_high_byte_ff <= WDATA;
      if (sel(ADDR, tmr_pkg::OFF_MODE))
        down_count_enable_ff <= WDATA[tmr_pkg::MODE_DOWN_COUNT_ENABLE_BIT];
      if (sel(ADDR, tmr_pkg::OFF_MASK))
        mask_ovf_ff <= WDATA[tmr_pkg::MASK_OVF_BIT];
    end
  end

  // control register; hardware set or toggle wins over a software write
  always_ff @(posedge SYS_CLK)
  begin
    if (RST)
      ctrl_ff <= tmr_pkg::CTRL_RST;
    else if (CE)
    begin
      if (WR && sel(ADDR, tmr_pkg::OFF_CTRL))
      begin
        ctrl_ff.external_flag         <= WDATA[6];
        ctrl_ff.receive_clock_select  <= WDATA[5];
        ctrl_ff.transmit_clock_select <= WDATA[4];
        ctrl_ff.run_control_bit       <= WDATA[2];
        ctrl_ff.counter_timer_select  <= WDATA[1];
        ctrl_ff.capture_reload_select <= WDATA[0];
        // flag is cleared by writing zero here, or by writing one to the status register
        if (!WDATA[7])
          ctrl_ff.ovf_flag <= 1'b0;
      end
      if (WR && sel(ADDR, tmr_pkg::OFF_STAT) && WDATA[tmr_pkg::STAT_OVF_BIT])
        ctrl_ff.ovf_flag <= 1'b0;
      if (ovf_set)
        ctrl_ff.ovf_flag <= 1'b1;
      if (ext_tgl)
        ctrl_ff.external_flag <= ~ctrl_ff.external_flag;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // read port and interrupt

  always_comb
  begin
    case (ADDR)
      tmr_pkg::OFF_CTRL:   rd_mux = {ctrl_ff[7:4], 1'b0, ctrl_ff[2:0]};
      tmr_pkg::OFF_MODE:   rd_mux = {7'h00, down_count_enable_ff};
      tmr_pkg::OFF_CNT_LO: rd_mux = count_low_byte_ff;
      tmr_pkg::OFF_CNT_HI: rd_mux = count_high_byte_ff;
      tmr_pkg::OFF_RLD_LO: rd_mux = reload_low_byte_ff;
      tmr_pkg::OFF_RLD_HI: rd_mux = reload_high_byte_ff;
      tmr_pkg::OFF_STAT:   rd_mux = {7'h00, ctrl_ff.ovf_flag};
      tmr_pkg::OFF_MASK:   rd_mux = {7'h00, mask_ovf_ff};
      default:             rd_mux = 8'h00;
    endcase
  end

  always_ff @(posedge SYS_CLK)
  begin
    if (RST)
      rdata_ff <= 8'h00;
    else if (CE)
      rdata_ff <= RD ? rd_mux : 8'h00;
  end

  // only the overflow flag reaches the interrupt line
  always_ff @(posedge SYS_CLK)
  begin
    if (RST)
      irq_ff <= 1'b0;
    else if (CE)
      irq_ff <= ctrl_ff.ovf_flag & mask_ovf_ff;
  end

  assign RDATA = rdata_ff;
  assign IRQ   = irq_ff;

  ////////////////////////////////////////////////////////////////////////
  // assertions

  AST_LOW_CARRY:
  assert property (@(posedge SYS_CLK) disable iff (RST)
    (evt.active && dir_up && !evt.hit_up && !cnt_wr && count_low_byte_ff == 8'hff)
    |=> (count_low_byte_ff == 8'h00) && (count_high_byte_ff == $past(count_high_byte_ff) + 8'h01))
  else $error("low byte did not carry into high byte");

  AST_PRESCALE:
  assert property (@(posedge SYS_CLK) disable iff (RST)
    (!ctrl_ff.counter_timer_select && !pre_wrap && !cnt_wr)
    |=> $stable(count))
  else $error("timer advanced off the divide-by-12 tick");

  AST_RUN_STOP:
  assert property (@(posedge SYS_CLK) disable iff (RST)
    (!ctrl_ff.run_control_bit && !cnt_wr) |=> $stable(count))
  else $error("count moved while stopped");

  AST_UP_ONLY:
  assert property (@(posedge SYS_CLK) disable iff (RST)
    (auto_mode && !down_count_enable_ff && evt.active && !evt.hit_up && !cnt_wr)
    |=> count == $past(count) + 16'h0001)
  else $error("plain auto-reload did not count up");

  AST_DOWN_STEP:
  assert property (@(posedge SYS_CLK) disable iff (RST)
    (updown && !pin_q[tmr_pkg::PIN_DIR] && evt.active && !evt.hit_dn && !cnt_wr)
    |=> count == $past(count) - 16'h0001)
  else $error("direction low did not count down");

  AST_OVF_FLAG:
  assert property (@(posedge SYS_CLK) disable iff (RST)
    (evt.wrap && evt.hit_up && !baud_mode)
    |=> ctrl_ff.ovf_flag ##1 (IRQ == $past(mask_ovf_ff)))
  else $error("overflow did not set flag and request");

  AST_UP_RELOAD:
  assert property (@(posedge SYS_CLK) disable iff (RST)
    (evt.wrap && evt.hit_up && reload_en) |=> count == $past(reload))
  else $error("overflow did not load reload value");

  AST_DOWN_WRAP:
  assert property (@(posedge SYS_CLK) disable iff (RST)
    (evt.wrap && evt.hit_dn) |=> (count == tmr_pkg::CNT_MAX) && ctrl_ff.ovf_flag)
  else $error("underflow did not load ffff and set flag");

  AST_EXT_TOGGLE:
  assert property (@(posedge SYS_CLK) disable iff (RST)
    (evt.wrap && updown) |=> ctrl_ff.external_flag != $past(ctrl_ff.external_flag))
  else $error("external flag did not toggle on wrap");

  AST_NO_EXT_IRQ:
  assert property (@(posedge SYS_CLK) disable iff (RST)
    (CE && !(ctrl_ff.ovf_flag && mask_ovf_ff)) |=> !IRQ)
  else $error("interrupt raised without overflow flag");

  AST_BAUD_NO_FLAG:
  assert property (@(posedge SYS_CLK) disable iff (RST)
    (!ctrl_ff.ovf_flag && baud_mode) |=> !ctrl_ff.ovf_flag)
  else $error("overflow flag set with a clock select high");

  AST_PIN_EDGE:
  assert property (@(posedge SYS_CLK) disable iff (RST)
    (ctrl_ff.counter_timer_select && !pin_fall[tmr_pkg::PIN_COUNT] && !cnt_wr)
    |=> $stable(count))
  else $error("counter advanced without a falling edge");

endmodule // tmr_updown_timer

// [tb/tmr_pin_model.sv]
// model of the external count and direction pins
`timescale 1ns/1ps
module tmr_pin_model (
  input  wire logic clk,       // system clock
  input  wire logic fall_req,  // ask for one falling edge on the count pin
  input  wire logic dir_up,    // wanted count direction
  output logic      count_pin, // external count input level
  output logic      dir_pin    // external direction level
);
  logic [1:0] low_cnt = 2'h0;

  initial dir_pin = 1'b0;

  ////////////////////////////////////////////////////////////////////////////
  // hold the pin low three cycles so the synchroniser cannot miss it
  always @(posedge clk)
  begin
    if (fall_req)
      low_cnt <= 2'h3;
    else if (low_cnt != 2'h0)
      low_cnt <= low_cnt - 2'h1;
  end

  assign count_pin = (low_cnt == 2'h0);

  ////////////////////////////////////////////////////////////////////////////
  // high counts up, low counts down
  always @(posedge clk)
    dir_pin <= dir_up;
endmodule  // tmr_pin_model

// [tb/tmr_updown_timer_test.sv]
// self-checking bench for the up/down auto-reload timer
`timescale 1ns/1ps
module tmr_updown_timer_test;
  logic       sys_clk    = 1'b0;
  logic       rst        = 1'b1;
  logic       ce         = 1'b1;
  logic [3:0] addr       = 4'h0;
  logic [7:0] wdata      = 8'h00;
  logic       wr_s       = 1'b0;
  logic       rd_s       = 1'b0;
  logic [7:0] rdata;
  logic       irq;
  logic       count_pin;
  logic       dir_pin;
  logic       fall_req   = 1'b0;
  logic       dir_up     = 1'b0;
  int         error_cnt  = 0;
  int         num_checks = 0;
  int         cycles     = 0;

  always #5 sys_clk = ~sys_clk;

  tmr_updown_timer DUT (
    .SYS_CLK         (sys_clk),
    .RST             (rst),
    .CE              (ce),
    .ADDR            (addr),
    .WDATA           (wdata),
    .WR              (wr_s),
    .RD              (rd_s),
    .RDATA           (rdata),
    .COUNT_INPUT_PIN (count_pin),
    .DIRECTION_PIN   (dir_pin),
    .IRQ             (irq)
  );

  tmr_pin_model PIN (
    .clk       (sys_clk),
    .fall_req  (fall_req),
    .dir_up    (dir_up),
    .count_pin (count_pin),
    .dir_pin   (dir_pin)
  );

  ////////////////////////////////////////////////////////////////////////////
  task automatic complete_run;
    if (error_cnt == 0 && num_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    addr  <= a;
    wdata <= d;
    wr_s  <= 1'b1;
    @(posedge sys_clk);
    wr_s  <= 1'b0;
  endtask

  task automatic rd(input logic [3:0] a, input logic [7:0] exp);
    @(posedge sys_clk);
    addr <= a;
    rd_s <= 1'b1;
    @(posedge sys_clk);
    rd_s <= 1'b0;
    #1;
    chk(rdata, exp);
  endtask

  task automatic ld(input logic [3:0] lo_off, input logic [15:0] v);
    wr(lo_off, v[7:0]);
    wr(lo_off + 4'h1, v[15:8]);
  endtask

  task automatic rd16(input logic [15:0] exp);
    rd(tmr_pkg::OFF_CNT_LO, exp[7:0]);
    rd(tmr_pkg::OFF_CNT_HI, exp[15:8]);
  endtask

  task automatic pulse;
    @(posedge sys_clk);
    fall_req <= 1'b1;
    @(posedge sys_clk);
    fall_req <= 1'b0;
    repeat (8) @(posedge sys_clk);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  always @(posedge sys_clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 5000)
    begin
      error_cnt++;
      complete_run();
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (5) @(posedge sys_clk);
    rst <= 1'b0;
    // all registers and one unmapped place read zero
    for (int i = 0; i < 9; i++)
      rd(i[3:0], 8'h00);
    // timer mode: 120 running cycles give exactly ten ticks
    ld(tmr_pkg::OFF_CNT_LO, 16'h00fc);
    wr(tmr_pkg::OFF_CTRL, 8'h04);
    repeat (118) @(posedge sys_clk);
    wr(tmr_pkg::OFF_CTRL, 8'h00);
    rd16(16'h0106);
    repeat (40) @(posedge sys_clk);
    rd16(16'h0106);
    // enable low freezes prescaler and count: twelve enabled running cycles give one tick
    wr(tmr_pkg::OFF_CTRL, 8'h04);
    ce <= 1'b0;
    repeat (60) @(posedge sys_clk);
    ce <= 1'b1;
    repeat (10) @(posedge sys_clk);
    wr(tmr_pkg::OFF_CTRL, 8'h00);
    rd16(16'h0107);
    // counter mode, plain up count with direction pin low
    wr(tmr_pkg::OFF_MASK, 8'h01);
    ld(tmr_pkg::OFF_RLD_LO, 16'h1234);
    ld(tmr_pkg::OFF_CNT_LO, 16'hfffe);
    wr(tmr_pkg::OFF_CTRL, 8'h06);
    pulse();
    rd16(16'hffff);
    chk({7'h00, irq}, 8'h00);
    pulse();
    rd16(16'h1234);
    rd(tmr_pkg::OFF_CTRL, 8'h86);
    chk({7'h00, irq}, 8'h01);
    wr(tmr_pkg::OFF_STAT, 8'h01);
    rd(tmr_pkg::OFF_STAT, 8'h00);
    chk({7'h00, irq}, 8'h00);
    // masked overflow sets the flag without a request
    wr(tmr_pkg::OFF_MASK, 8'h00);
    ld(tmr_pkg::OFF_CNT_LO, 16'hffff);
    pulse();
    rd(tmr_pkg::OFF_STAT, 8'h01);
    chk({7'h00, irq}, 8'h00);
    wr(tmr_pkg::OFF_STAT, 8'h01);
    // transmit clock select reloads but leaves the flag alone
    ld(tmr_pkg::OFF_CNT_LO, 16'hffff);
    wr(tmr_pkg::OFF_CTRL, 8'h16);
    pulse();
    rd16(16'h1234);
    rd(tmr_pkg::OFF_CTRL, 8'h16);
    // receive clock select behaves the same way
    ld(tmr_pkg::OFF_CNT_LO, 16'hffff);
    wr(tmr_pkg::OFF_CTRL, 8'h26);
    pulse();
    rd16(16'h1234);
    rd(tmr_pkg::OFF_CTRL, 8'h26);
    // capture mode wraps to zero
    wr(tmr_pkg::OFF_CTRL, 8'h07);
    ld(tmr_pkg::OFF_CNT_LO, 16'hffff);
    pulse();
    rd16(16'h0000);
    rd(tmr_pkg::OFF_CTRL, 8'h87);
    // up/down mode: down to the reload value, then wrap to ffff
    wr(tmr_pkg::OFF_MODE, 8'h01);
    wr(tmr_pkg::OFF_CTRL, 8'h06);
    wr(tmr_pkg::OFF_MASK, 8'h01);
    ld(tmr_pkg::OFF_CNT_LO, 16'h1235);
    pulse();
    rd16(16'h1234);
    pulse();
    rd16(16'hffff);
    rd(tmr_pkg::OFF_CTRL, 8'hc6);
    wr(tmr_pkg::OFF_STAT, 8'h01);
    rd(tmr_pkg::OFF_CTRL, 8'h46);
    chk({7'h00, irq}, 8'h00);
    @(posedge sys_clk);
    dir_up <= 1'b1;
    pulse();
    rd16(16'h1234);
    rd(tmr_pkg::OFF_CTRL, 8'h86);
    complete_run();
  end
endmodule  // tmr_updown_timer_test
